// File: cmp_irq_defines.svh
// Register map, field positions and reset values for the comparator interrupt block.
// Assumes byte-addressed AXI4-Lite with one register per aligned 32-bit word.
`ifndef CMP_IRQ_DEFINES_SVH
`define CMP_IRQ_DEFINES_SVH

`define ADDR_W            8
// Printed offset kept as a word index; the bus address is four times it
`define IDX_INTCTL        8'h0B
`define OFS_INTCTL        8'h2C
`define OFS_PERIPHERAL_IRQ_ENABLE_2          8'h10
`define OFS_CTL1_C1       8'h14
`define OFS_CTL1_C2       8'h18
`define OFS_MIRROR        8'h1C
`define OFS_FLAGS         8'h20
`define OFS_FLAG_CLR      8'h24
`define OFS_GLOBAL_IRQ    8'h28
`define INTCTL_GIE_BIT    7
`define INTCTL_PERIPHERAL_IRQ_GATE_BIT   6
`define PERIPHERAL_IRQ_ENABLE_2_CMP2_IRQ_EN_BIT     6
`define PERIPHERAL_IRQ_ENABLE_2_CMP1_IRQ_EN_BIT     5
`define PERIPHERAL_IRQ_ENABLE_2_MASK         8'hFD
`define CTL1_RISE_BIT     7
`define CTL1_FALL_BIT     6
`define CTL1_MASK         8'hF3
`define RST_BYTE          8'h00
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// File: cmp_irq_pkg.sv
// Types shared by the comparator interrupt block.
// Assumes cmp_irq_defines.svh is compiled alongside.
package cmp_irq_pkg;

  typedef struct packed {
    logic [1:0] pos_input_select;
    logic [1:0] neg_input_select;
  } cmp_route_t;

  typedef struct packed {
    logic [7:0]  interrupt_control;
    logic [7:0]  peripheral_irq_enable_2;
    logic [7:0]  comparator_control_1_c1;
    logic [7:0]  comparator_control_1_c2;
    logic [1:0]  comparator_irq_flag;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic [1:0]  prev;
    logic [1:0]  rise;
    logic [1:0]  fall;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        irq;
    cmp_route_t  route1;
    cmp_route_t  route2;
  } state_t;

endpackage

// File: cmp_irq_ctrl.sv
// Comparator edge interrupt control: edge flags, input routing, mirror, enables.
// Assumes an AXI4-Lite master on clk; comparator outputs are asynchronous.
//
// Behaviour
// - Rising-edge enable set makes comparator output rise set its flag.
// - Falling-edge enable set makes comparator output fall set its flag.
// - Positive select: 00 pin, 01 DAC, 10 fixed reference, 11 ground.
// - Negative select codes 00 to 11 pick shared pins zero to three.
// - Mirror register shows comparator 2 at bit 1, comparator 1 at bit 0.
// - Comparator 2 interrupt passes only while its enable bit 6 is one.
// - Comparator 1 interrupt passes only while its enable bit 5 is one.
// - Peripheral gate bit must be set for any comparator interrupt to pass.
`timescale 1ns/1ps
`include "cmp_irq_defines.svh"
`default_nettype none

module cmp_irq_ctrl (
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  input  wire logic [1:0]            comparator_result,
  input  wire logic [`ADDR_W-1:0]    s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic                       s_axi_bvalid,
  output logic [1:0]                 s_axi_bresp,
  input  wire logic                  s_axi_bready,
  input  wire logic [`ADDR_W-1:0]    s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic                       s_axi_rvalid,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  input  wire logic                  s_axi_rready,
  output cmp_irq_pkg::cmp_route_t    route_c1,
  output cmp_irq_pkg::cmp_route_t    route_c2,
  output logic                       irq
);

  cmp_irq_pkg::state_t s_q;
  cmp_irq_pkg::state_t s_d;

  // Route field of a control byte
  function automatic cmp_irq_pkg::cmp_route_t route_of(input logic [7:0] c);
    route_of.pos_input_select = c[5:4];
    route_of.neg_input_select = c[1:0];
  endfunction

  // Edge hits against per-comparator enables
  function automatic logic edge_hit(input logic [7:0] c, input logic r, input logic f);
    edge_hit = (c[`CTL1_RISE_BIT] & r) | (c[`CTL1_FALL_BIT] & f);
  endfunction

  logic aw_ok;
  logic ar_ok;
  logic [7:0] wbyte;
  logic [1:0] en_hit;
  logic [1:0] hit;

  // Write is taken only when address and data are both present
  assign aw_ok = s_axi_awvalid & s_axi_wvalid & ~s_q.bvalid;
  assign ar_ok = s_axi_arvalid & ~s_q.rvalid;
  assign wbyte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : `RST_BYTE;

  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    s_d = s_q;
    s_d.sync1 = comparator_result;
    s_d.sync2 = s_q.sync1;
    s_d.prev  = s_q.sync2;
    s_d.rise  = s_q.sync2 & ~s_q.prev;
    s_d.fall  = ~s_q.sync2 & s_q.prev;
    hit[0] = edge_hit(s_q.comparator_control_1_c1, s_q.rise[0], s_q.fall[0]);
    hit[1] = edge_hit(s_q.comparator_control_1_c2, s_q.rise[1], s_q.fall[1]);

    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end

    if (aw_ok) begin
      s_d.bvalid = 1'b1;
      s_d.bresp  = `RESP_OKAY;
      if (s_axi_wstrb[0]) begin
        unique case (s_axi_awaddr)
          `OFS_INTCTL:   s_d.interrupt_control = wbyte;
          `OFS_PERIPHERAL_IRQ_ENABLE_2:     s_d.peripheral_irq_enable_2 = wbyte & `PERIPHERAL_IRQ_ENABLE_2_MASK;
          `OFS_CTL1_C1:  s_d.comparator_control_1_c1 = wbyte & `CTL1_MASK;
          `OFS_CTL1_C2:  s_d.comparator_control_1_c2 = wbyte & `CTL1_MASK;
          // Write-one-to-clear; a same-cycle edge re-sets below
          `OFS_FLAG_CLR: s_d.comparator_irq_flag = s_q.comparator_irq_flag & ~wbyte[1:0];
          `OFS_MIRROR, `OFS_FLAGS, `OFS_GLOBAL_IRQ: ;
          default:       s_d.bresp = `RESP_SLVERR;
        endcase
      end
    end
    s_d.comparator_irq_flag = s_d.comparator_irq_flag | hit;

    if (ar_ok) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = `RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      unique case (s_axi_araddr)
        `OFS_INTCTL:     s_d.rdata[7:0] = s_q.interrupt_control;
        `OFS_PERIPHERAL_IRQ_ENABLE_2:       s_d.rdata[7:0] = s_q.peripheral_irq_enable_2;
        `OFS_CTL1_C1:    s_d.rdata[7:0] = s_q.comparator_control_1_c1;
        `OFS_CTL1_C2:    s_d.rdata[7:0] = s_q.comparator_control_1_c2;
        `OFS_MIRROR:     s_d.rdata[1:0] = s_q.sync2;
        `OFS_FLAGS:      s_d.rdata[1:0] = s_q.comparator_irq_flag;
        `OFS_GLOBAL_IRQ: s_d.rdata[0]   = s_q.irq;
        `OFS_FLAG_CLR:   ;
        default:         s_d.rresp = `RESP_SLVERR;
      endcase
    end

    en_hit[1] = s_q.comparator_irq_flag[1] & s_q.peripheral_irq_enable_2[`PERIPHERAL_IRQ_ENABLE_2_CMP2_IRQ_EN_BIT];
    en_hit[0] = s_q.comparator_irq_flag[0] & s_q.peripheral_irq_enable_2[`PERIPHERAL_IRQ_ENABLE_2_CMP1_IRQ_EN_BIT];
    // Global gate kept as a register bit only; the core never acts on it
    s_d.irq = s_q.interrupt_control[`INTCTL_PERIPHERAL_IRQ_GATE_BIT] & (|en_hit);

    s_d.route1 = route_of(s_d.comparator_control_1_c1);
    s_d.route2 = route_of(s_d.comparator_control_1_c2);
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // Ready is combinational on purpose: single-cycle accept, response from flops
  assign s_axi_awready = aw_ok;
  assign s_axi_wready  = aw_ok;
  assign s_axi_arready = ar_ok;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign route_c1      = s_q.route1;
  assign route_c2      = s_q.route2;
  assign irq           = s_q.irq;

  ////////////////////////////////////////////////////////////////////////////

  a_rise_sets_flag: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.rise[0] && s_q.comparator_control_1_c1[`CTL1_RISE_BIT] |=> s_q.comparator_irq_flag[0])
    else $error("rise did not set flag 1");
  a_fall_sets_flag: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.fall[1] && s_q.comparator_control_1_c2[`CTL1_FALL_BIT] |=> s_q.comparator_irq_flag[1])
    else $error("fall did not set flag 2");
  a_rise_sets_flag2: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.rise[1] && s_q.comparator_control_1_c2[`CTL1_RISE_BIT] |=> s_q.comparator_irq_flag[1])
    else $error("rise did not set flag 2");
  a_fall_sets_flag1: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.fall[0] && s_q.comparator_control_1_c1[`CTL1_FALL_BIT] |=> s_q.comparator_irq_flag[0])
    else $error("fall did not set flag 1");
  a_irq_raise: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.interrupt_control[`INTCTL_PERIPHERAL_IRQ_GATE_BIT] && s_q.comparator_irq_flag[0]
      && s_q.peripheral_irq_enable_2[`PERIPHERAL_IRQ_ENABLE_2_CMP1_IRQ_EN_BIT] |=> irq)
    else $error("enabled flag gave no irq");
  a_no_spurious_set: assert property (@(posedge clk) disable iff (!rst_b)
    !s_q.comparator_irq_flag[0] && !hit[0] |=> !s_q.comparator_irq_flag[0])
    else $error("flag 1 set without enabled edge");
  a_route_pos_sel: assert property (@(posedge clk) disable iff (!rst_b)
    route_c1.pos_input_select == s_q.comparator_control_1_c1[5:4])
    else $error("positive select mismatch");
  a_route_neg_sel: assert property (@(posedge clk) disable iff (!rst_b)
    route_c2.neg_input_select == s_q.comparator_control_1_c2[1:0])
    else $error("negative select mismatch");
  a_mirror_read: assert property (@(posedge clk) disable iff (!rst_b)
    ar_ok && s_axi_araddr == `OFS_MIRROR |=> s_axi_rdata == {30'h0, $past(s_q.sync2)})
    else $error("mirror read wrong");
  a_c2_gate: assert property (@(posedge clk) disable iff (!rst_b)
    !s_q.peripheral_irq_enable_2[`PERIPHERAL_IRQ_ENABLE_2_CMP2_IRQ_EN_BIT] && !s_q.comparator_irq_flag[0] |=> !irq)
    else $error("comparator 2 leaked");
  a_c1_gate: assert property (@(posedge clk) disable iff (!rst_b)
    !s_q.peripheral_irq_enable_2[`PERIPHERAL_IRQ_ENABLE_2_CMP1_IRQ_EN_BIT] && !s_q.comparator_irq_flag[1] |=> !irq)
    else $error("comparator 1 leaked");
  a_peripheral_irq_gate_gate: assert property (@(posedge clk) disable iff (!rst_b)
    !s_q.interrupt_control[`INTCTL_PERIPHERAL_IRQ_GATE_BIT] |=> !irq)
    else $error("irq without peripheral gate");
  a_edge_one_cycle: assert property (@(posedge clk) disable iff (!rst_b)
    s_q.rise[0] |=> !s_q.rise[0])
    else $error("edge longer than a cycle");

  c_rise_flag: cover property (@(posedge clk) disable iff (!rst_b) $rose(s_q.comparator_irq_flag[0]));
  c_irq_high:  cover property (@(posedge clk) disable iff (!rst_b) $rose(irq));
  c_clear_flag: cover property (@(posedge clk) disable iff (!rst_b) $fell(s_q.comparator_irq_flag[1]));
  c_fall_flag2: cover property (@(posedge clk) disable iff (!rst_b)
    s_q.fall[1] && s_q.comparator_control_1_c2[`CTL1_FALL_BIT]);

endmodule

`default_nettype wire

// File: cmp_model.sv
// Behavioural pair of comparators behind the input routing selects.
// Assumes the bench sets every input level; output is high when plus exceeds minus.
`timescale 1ns/1ps
`default_nettype none
module cmp_model (
  input  wire cmp_irq_pkg::cmp_route_t route_c1,
  input  wire cmp_irq_pkg::cmp_route_t route_c2,
  input  wire logic [15:0]             pos_pin,
  input  wire logic [31:0]             neg_pin,
  input  wire logic [7:0]              dac_lvl,
  input  wire logic [7:0]              fvr_lvl,
  output logic [1:0]                   comparator_result
);
  function automatic logic cmp(input cmp_irq_pkg::cmp_route_t r, input logic [7:0] p);
    logic [7:0] vp;
    case (r.pos_input_select)
      2'h0: vp = p;
      2'h1: vp = dac_lvl;
      2'h2: vp = fvr_lvl;
      default: vp = 8'h00;
    endcase
    return vp > neg_pin[r.neg_input_select*8 +: 8];
  endfunction
  always_comb begin
    comparator_result = {cmp(route_c2, pos_pin[15:8]), cmp(route_c1, pos_pin[7:0])};
  end
endmodule
`default_nettype wire

// File: comparator_edge_irq_ctrl_tb_top.sv
// Self-checking bench for the comparator interrupt block.
// Assumes cmp_model as the analog side and an AXI4-Lite master driven here.
`timescale 1ns/1ps
`include "cmp_irq_defines.svh"
`default_nettype none
module comparator_edge_irq_ctrl_tb_top;
  logic        clk, rst_b, awvalid, wvalid, bvalid, bready, awready, wready, irq;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr, dac_lvl, fvr_lvl;
  logic [31:0] wdata, rdata, neg_pin;
  logic [15:0] pos_pin;
  logic [1:0]  bresp, rresp, cres;
  cmp_irq_pkg::cmp_route_t r1, r2;
  int          err_count = 0, check_count = 0, cyc = 0;
  cmp_irq_ctrl dut_u (.clk(clk), .rst_b(rst_b), .comparator_result(cres),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bvalid(bvalid), .s_axi_bresp(bresp),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rvalid(rvalid), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rready(rready), .route_c1(r1), .route_c2(r2), .irq(irq));
  cmp_model cm_u (.route_c1(r1), .route_c2(r2), .pos_pin(pos_pin), .neg_pin(neg_pin),
    .dac_lvl(dac_lvl), .fvr_lvl(fvr_lvl), .comparator_result(cres));
  always #5 clk = ~clk;
  task automatic end_sim;
    if (err_count == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h000000, d};
    {awvalid, wvalid, bready} <= 3'h7;
    do @(posedge clk); while (awready !== 1'b1);
    {awvalid, wvalid} <= 2'h0;
    do @(posedge clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(bresp, `RESP_OKAY, "bresp");
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do @(posedge clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rresp, er, "rresp");
    if (er == `RESP_OKAY) chk(rdata, {24'h000000, e}, "rdata");
    @(posedge clk);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    chk(irq, 1'b0, "irq reset");
    rd(`OFS_INTCTL, `RST_BYTE, `RESP_OKAY);
    rd(`OFS_PERIPHERAL_IRQ_ENABLE_2, `RST_BYTE, `RESP_OKAY);
    rd(`OFS_CTL1_C1, `RST_BYTE, `RESP_OKAY);
    rd(`OFS_CTL1_C2, `RST_BYTE, `RESP_OKAY);
    rd(`OFS_FLAGS, 8'h00, `RESP_OKAY);
    wr(`OFS_PERIPHERAL_IRQ_ENABLE_2, 8'hFF);
    rd(`OFS_PERIPHERAL_IRQ_ENABLE_2, `PERIPHERAL_IRQ_ENABLE_2_MASK, `RESP_OKAY);
    wr(`OFS_CTL1_C1, 8'hFF);
    rd(`OFS_CTL1_C1, `CTL1_MASK, `RESP_OKAY);
    rd(8'h40, 8'h00, `RESP_SLVERR);
  endtask
  task automatic t_route;
    logic [7:0] vp [4];
    logic [7:0] vn [4];
    vp = '{8'h80, 8'h40, 8'hC0, 8'h00};
    vn = '{8'h30, 8'h50, 8'hB0, 8'h10};
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_CTL1_C1, {2'h0, i[1:0], 2'h0, i[1:0]});
      wr(`OFS_CTL1_C2, {2'h0, ~i[1:0], 2'h0, ~i[1:0]});
      chk(r1, {i[1:0], i[1:0]}, "route c1");
      chk(r2, {~i[1:0], ~i[1:0]}, "route c2");
      repeat (4) @(posedge clk);
      rd(`OFS_MIRROR, {6'h00, vp[3-i] > vn[3-i], vp[i] > vn[i]}, `RESP_OKAY);
    end
  endtask
  // Plus pin low first so the rerouting below makes no stray edge
  task automatic t_edge;
    pos_pin <= 16'h0000;
    for (int k = 0; k < 4; k++) begin
      wr(`OFS_CTL1_C1, {k[1:0], 6'h00});
      wr(`OFS_CTL1_C2, {k[1:0], 6'h00});
      wr(`OFS_FLAG_CLR, 8'h03);
      pos_pin <= 16'hFFFF;
      repeat (6) @(posedge clk);
      rd(`OFS_FLAGS, {6'h00, k[1], k[1]}, `RESP_OKAY);
      wr(`OFS_FLAG_CLR, 8'h03);
      pos_pin <= 16'h0000;
      repeat (6) @(posedge clk);
      rd(`OFS_FLAGS, {6'h00, k[0], k[0]}, `RESP_OKAY);
    end
  endtask
  task automatic t_irq;
    logic [1:0] f;
    f = 2'h0;
    pos_pin <= 16'h0000;
    wr(`OFS_CTL1_C1, 8'h80);
    wr(`OFS_CTL1_C2, 8'h80);
    repeat (6) @(posedge clk);
    wr(`OFS_FLAG_CLR, 8'h03);
    for (int s = 0; s < 3; s++) begin
      for (int g = 0; g < 8; g++) begin
        wr(`OFS_INTCTL, {1'b0, g[2], 6'h00});
        wr(`OFS_PERIPHERAL_IRQ_ENABLE_2, {1'b0, g[1:0], 5'h00});
        repeat (2) @(posedge clk);
        chk(irq, g[2] & ((g[1] & f[1]) | (g[0] & f[0])), "irq");
      end
      f = {f[0], 1'b1};
      pos_pin <= {{8{f[1]}}, {8{f[0]}}};
      repeat (6) @(posedge clk);
    end
    wr(`OFS_FLAG_CLR, 8'h03);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0, "irq clear");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {clk, rst_b, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
    {awaddr, araddr, wdata} = 48'h0;
    {pos_pin, dac_lvl, fvr_lvl} = {16'h8080, 8'h40, 8'hC0};
    neg_pin = 32'h10B05030;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    t_regs;
    t_route;
    t_edge;
    t_irq;
    end_sim;
  end
  // Cycle ceiling well above the whole sequence
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      end_sim;
    end
  end
endmodule
`default_nettype wire
